/* logic/dim_params.svh */
// constants of the digital input value mapper
`ifndef DIM_PARAMS_SVH
`define DIM_PARAMS_SVH

`define DIM_NUM_CHAN 5
`define DIM_VAL_W 16
`define DIM_DEST_W 11

// value limits in hundredths of a percent (+/-300.00 %)
`define DIM_VAL_MAX 16'h7530
`define DIM_VAL_MIN 16'h8AD0
`define DIM_VAL_ZERO 16'h0000

// reset levels: 0.01 % for true, 0.00 % for false
`define DIM_VTRUE_RST 16'h0001
`define DIM_VFALSE_RST 16'h0000

// reset destinations: limit select, ramp freeze, demand bypass
`define DIM_DEST0_RST 11'h05A
`define DIM_DEST1_RST 11'h076
`define DIM_DEST2_RST 11'h077
`define DIM_DEST3_RST 11'h000
`define DIM_DEST4_RST 11'h000

// register map, byte addresses
`define DIM_ADDR_CTRL 8'h00
`define DIM_ADDR_STATUS 8'h04
`define DIM_CHAN_FIRST 4'h1
`define DIM_CHAN_LAST 4'h5
`define DIM_OFS_VTRUE 4'h0
`define DIM_OFS_VFALSE 4'h4
`define DIM_OFS_DEST 4'h8
`define DIM_OFS_OUT 4'hC

// control bits
`define DIM_CTRL_UNLOCK 0
`define DIM_CTRL_ILK_EN 1
`define DIM_ILK_EN_RST 1'b1

// status bits
`define DIM_STAT_ILK_DIS 5
`define DIM_STAT_ANALOG 6

// cycles from reset release until outputs carry valid data
`define DIM_FILL_DONE 2'h3

`define DIM_INTERLOCK_CH 4

`endif

/* logic/dim_pkg.sv */
// types of the digital input value mapper
package dim_pkg;

    typedef struct packed {
        logic [10:0] dest;
        logic [15:0] value;
        logic level;
    } dim_chan_s;

    typedef struct packed {
        logic [4:0] sync1;
        logic [4:0] state;
        logic unlock;
        logic ilk_en;
        logic ilk_dis;
        logic analog_level;
        logic [4:0][15:0] vtrue;
        logic [4:0][15:0] vfalse;
        logic [4:0][10:0] dest;
        logic [4:0][15:0] outv;
        logic [4:0] outl;
        logic [1:0] fill;
        logic wr_en;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic rd_wait;
        logic [31:0] rdata;
    } dim_state_s;

endpackage

/* logic/dim_top.sv */
// digital input value mapper with AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
`include "dim_params.svh"

module dim_top
    import dim_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic first_input_terminal,
    input wire logic second_input_terminal,
    input wire logic third_input_terminal,
    input wire logic fourth_input_terminal,
    input wire logic interlock_terminal,
    input wire logic [15:0] analog_in,
    output logic analog_level,
    output logic [4:0] chan_state,
    output var dim_chan_s [4:0] chan_out,
    output logic chan_wr_en,
    output logic current_loop_disable
);

    localparam dim_state_s DIM_RST = '{
        vtrue: {5{`DIM_VTRUE_RST}},
        vfalse: {5{`DIM_VFALSE_RST}},
        dest: {`DIM_DEST4_RST, `DIM_DEST3_RST, `DIM_DEST2_RST, `DIM_DEST1_RST, `DIM_DEST0_RST},
        ilk_en: `DIM_ILK_EN_RST,
        default: '0
    };

    dim_state_s s_reg;
    dim_state_s s_next;
    logic [4:0] terminals;
    logic [2:0] ap_ch;
    logic ap_in_chan;
    logic rd_stall;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic [15:0] clamp_val(input logic [15:0] v);
        logic [15:0] r;
        r = v;
        if ($signed(v) > $signed(`DIM_VAL_MAX)) begin
            r = `DIM_VAL_MAX;
        end else if ($signed(v) < $signed(`DIM_VAL_MIN)) begin
            r = `DIM_VAL_MIN;
        end
        return r;
    endfunction

    assign terminals = {interlock_terminal, fourth_input_terminal, third_input_terminal,
                        second_input_terminal, first_input_terminal};
    assign ap_in_chan = (s_reg.ap_addr[7:4] >= `DIM_CHAN_FIRST) && (s_reg.ap_addr[7:4] <= `DIM_CHAN_LAST);
    assign ap_ch = 3'(s_reg.ap_addr[7:4] - `DIM_CHAN_FIRST);
    // a read holds the data phase for one wait state
    assign rd_stall = s_reg.ap_valid && !s_reg.ap_write && !s_reg.rd_wait;

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        s_next = s_reg;

        s_next.sync1 = terminals;
        s_next.state = s_reg.sync1;

        for (int i = 0; i < `DIM_NUM_CHAN; i++) begin
            s_next.outv[i] = s_reg.state[i] ? s_reg.vtrue[i] : s_reg.vfalse[i];
            s_next.outl[i] = $signed(s_next.outv[i]) > $signed(`DIM_VAL_ZERO);
        end

        s_next.analog_level = $signed(analog_in) > $signed(`DIM_VAL_ZERO);
        s_next.ilk_dis = s_reg.ilk_en && !s_reg.state[`DIM_INTERLOCK_CH];

        if (s_reg.fill != `DIM_FILL_DONE) begin
            s_next.fill = s_reg.fill + 2'h1;
        end
        s_next.wr_en = (s_reg.fill == `DIM_FILL_DONE);

        // write data phase
        if (s_reg.ap_valid && s_reg.ap_write) begin
            if (s_reg.ap_addr == `DIM_ADDR_CTRL) begin
                s_next.unlock = hwdata[`DIM_CTRL_UNLOCK];
                s_next.ilk_en = hwdata[`DIM_CTRL_ILK_EN];
            end else if (s_reg.unlock && ap_in_chan) begin
                unique case (s_reg.ap_addr[3:0])
                    `DIM_OFS_VTRUE: begin
                        s_next.vtrue[ap_ch] = clamp_val(hwdata[15:0]);
                    end
                    `DIM_OFS_VFALSE: begin
                        s_next.vfalse[ap_ch] = clamp_val(hwdata[15:0]);
                    end
                    `DIM_OFS_DEST: begin
                        s_next.dest[ap_ch] = hwdata[10:0];
                    end
                    default: begin
                    end
                endcase
            end
        end

        // read data phase, first cycle loads the answer
        if (rd_stall) begin
            s_next.rd_wait = 1'b1;
            s_next.rdata = '0;
            if (s_reg.ap_addr == `DIM_ADDR_CTRL) begin
                s_next.rdata[`DIM_CTRL_UNLOCK] = s_reg.unlock;
                s_next.rdata[`DIM_CTRL_ILK_EN] = s_reg.ilk_en;
            end else if (s_reg.ap_addr == `DIM_ADDR_STATUS) begin
                s_next.rdata[4:0] = s_reg.state;
                s_next.rdata[`DIM_STAT_ILK_DIS] = s_reg.ilk_dis;
                s_next.rdata[`DIM_STAT_ANALOG] = s_reg.analog_level;
            end else if (ap_in_chan) begin
                unique case (s_reg.ap_addr[3:0])
                    `DIM_OFS_VTRUE: begin
                        s_next.rdata = {{16{s_reg.vtrue[ap_ch][15]}}, s_reg.vtrue[ap_ch]};
                    end
                    `DIM_OFS_VFALSE: begin
                        s_next.rdata = {{16{s_reg.vfalse[ap_ch][15]}}, s_reg.vfalse[ap_ch]};
                    end
                    `DIM_OFS_DEST: begin
                        s_next.rdata[10:0] = s_reg.dest[ap_ch];
                    end
                    `DIM_OFS_OUT: begin
                        s_next.rdata = {{16{s_reg.outv[ap_ch][15]}}, s_reg.outv[ap_ch]};
                    end
                    default: begin
                    end
                endcase
            end
        end

        // address phase taken when the bus is ready and no read wait state is pending
        if (hready && !rd_stall) begin
            s_next.ap_valid = hsel && htrans[1];
            s_next.ap_write = hwrite;
            s_next.ap_addr = haddr[7:0];
            s_next.rd_wait = 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_reg <= DIM_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < `DIM_NUM_CHAN; i++) begin
            chan_out[i].dest = s_reg.dest[i];
            chan_out[i].value = s_reg.outv[i];
            chan_out[i].level = s_reg.outl[i];
        end
    end

    assign hreadyout = !rd_stall;
    assign hresp = 1'b0;
    assign hrdata = s_reg.rdata;
    assign chan_state = s_reg.state;
    assign chan_wr_en = s_reg.wr_en;
    assign analog_level = s_reg.analog_level;
    assign current_loop_disable = s_reg.ilk_dis;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking dim_cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    logic past_valid;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            past_valid <= 1'b0;
        end else begin
            past_valid <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // data phase decode for checks
    // ---------------------------------------------------------------
    logic dp_write;
    logic dp_chan_wr;
    logic dp_rd_ctrl;
    logic dp_rd_status;
    logic dp_rd_chan;
    logic dp_in_range;
    assign dp_write = s_reg.ap_valid && s_reg.ap_write;
    assign dp_chan_wr = s_reg.unlock && dp_write && ap_in_chan;
    assign dp_rd_ctrl = rd_stall && (s_reg.ap_addr == `DIM_ADDR_CTRL);
    assign dp_rd_status = rd_stall && (s_reg.ap_addr == `DIM_ADDR_STATUS);
    assign dp_rd_chan = rd_stall && ap_in_chan;
    // in-range writes must land unchanged, others saturate
    assign dp_in_range = ($signed(hwdata[15:0]) <= $signed(`DIM_VAL_MAX)) &&
                         ($signed(hwdata[15:0]) >= $signed(`DIM_VAL_MIN));

    for (genvar g = 0; g < `DIM_NUM_CHAN; g++) begin : g_chk
        a_out_follow: assert property (past_valid |->
            chan_out[g].value == ($past(chan_state[g]) ? $past(s_reg.vtrue[g]) : $past(s_reg.vfalse[g])))
            else $error("channel output does not follow level value");
        a_val_range: assert property ($signed(s_reg.vtrue[g]) <= $signed(`DIM_VAL_MAX) &&
            $signed(s_reg.vfalse[g]) >= $signed(`DIM_VAL_MIN))
            else $error("level value out of range");
        a_logic_map: assert property (chan_out[g].level == ($signed(chan_out[g].value) > 0))
            else $error("logic level does not match output value");
        a_state_sync: assert property (past_valid && $past(past_valid) |->
            chan_state[g] == $past(terminals[g], 2))
            else $error("channel state not two cycles behind terminal");
        a_true_level: assert property (chan_state[g] |=> chan_out[g].value == $past(s_reg.vtrue[g]))
            else $error("true terminal not giving high level value");
        a_false_level: assert property (!chan_state[g] |=> chan_out[g].value == $past(s_reg.vfalse[g]))
            else $error("false terminal not giving low level value");
        a_vtrue_write: assert property (dp_chan_wr && ap_ch == 3'(g) &&
            s_reg.ap_addr[3:0] == `DIM_OFS_VTRUE && dp_in_range |=> s_reg.vtrue[g] == $past(hwdata[15:0]))
            else $error("high level value write lost");
        a_vfalse_write: assert property (dp_chan_wr && ap_ch == 3'(g) &&
            s_reg.ap_addr[3:0] == `DIM_OFS_VFALSE && dp_in_range |=> s_reg.vfalse[g] == $past(hwdata[15:0]))
            else $error("low level value write lost");
        a_dest_write: assert property (dp_chan_wr && ap_ch == 3'(g) &&
            s_reg.ap_addr[3:0] == `DIM_OFS_DEST |=> s_reg.dest[g] == $past(hwdata[10:0]))
            else $error("destination write lost");
        a_clamp_high: assert property (dp_chan_wr && ap_ch == 3'(g) && s_reg.ap_addr[3:0] == `DIM_OFS_VTRUE &&
            $signed(hwdata[15:0]) > $signed(`DIM_VAL_MAX) |=> s_reg.vtrue[g] == `DIM_VAL_MAX)
            else $error("high level value not clamped");
        a_clamp_low: assert property (dp_chan_wr && ap_ch == 3'(g) && s_reg.ap_addr[3:0] == `DIM_OFS_VFALSE &&
            $signed(hwdata[15:0]) < $signed(`DIM_VAL_MIN) |=> s_reg.vfalse[g] == `DIM_VAL_MIN)
            else $error("low level value not clamped");
        a_lock_vfalse: assert property (!s_reg.unlock && dp_write |=>
            $stable(s_reg.vfalse[g]))
            else $error("locked low level value changed");
        a_vtrue_read: assert property (dp_rd_chan && ap_ch == 3'(g) && s_reg.ap_addr[3:0] == `DIM_OFS_VTRUE |=>
            hrdata[15:0] == $past(s_reg.vtrue[g]))
            else $error("high level value read wrong");
        a_vfalse_read: assert property (dp_rd_chan && ap_ch == 3'(g) && s_reg.ap_addr[3:0] == `DIM_OFS_VFALSE |=>
            hrdata[15:0] == $past(s_reg.vfalse[g]))
            else $error("low level value read wrong");
        a_dest_read: assert property (dp_rd_chan && ap_ch == 3'(g) && s_reg.ap_addr[3:0] == `DIM_OFS_DEST |=>
            hrdata[10:0] == $past(s_reg.dest[g]))
            else $error("destination read wrong");
        a_out_read: assert property (dp_rd_chan && ap_ch == 3'(g) && s_reg.ap_addr[3:0] == `DIM_OFS_OUT |=>
            hrdata[15:0] == $past(chan_out[g].value))
            else $error("output value read wrong");
        a_reset_out: assert property (@(posedge hclk) $rose(hresetn) |->
            chan_out[g].value == '0 && !chan_out[g].level)
            else $error("channel output not cleared by reset");
    end

    a_reset_dflt: assert property (@(posedge hclk) $rose(hresetn) |->
        s_reg.vtrue[0] == `DIM_VTRUE_RST && s_reg.vfalse[0] == `DIM_VFALSE_RST)
        else $error("level values not at reset defaults");
    a_dest_dflt: assert property (@(posedge hclk) $rose(hresetn) |->
        chan_out[0].dest == `DIM_DEST0_RST && chan_out[1].dest == `DIM_DEST1_RST &&
        chan_out[2].dest == `DIM_DEST2_RST)
        else $error("destinations not at reset defaults");
    a_invert_chan: assert property (s_reg.vtrue[0] == '0 && $signed(s_reg.vfalse[0]) > 0 &&
        $stable(s_reg.vtrue[0]) && $stable(s_reg.vfalse[0]) ##0 !chan_state[0] |=> chan_out[0].level)
        else $error("inverted channel not sending one on false");
    a_dest_lock: assert property (!s_reg.unlock && s_reg.ap_valid && s_reg.ap_write |=>
        $stable(s_reg.dest) && $stable(s_reg.vtrue))
        else $error("locked configuration changed");
    a_analog_map: assert property (past_valid |-> analog_level == ($signed($past(analog_in)) > 0))
        else $error("analog logic level wrong");
    a_interlock: assert property (s_reg.ilk_en && !chan_state[`DIM_INTERLOCK_CH] |=>
        current_loop_disable)
        else $error("current loop not disabled on interlock loss");
    a_wr_en_fill: assert property ($rose(chan_wr_en) |-> $past(past_valid, 2))
        else $error("write enable before outputs valid");
    a_rd_wait: assert property (rd_stall |=> hreadyout && s_reg.rd_wait)
        else $error("read wait state longer than one cycle");

    // ---------------------------------------------------------------
    // bus and status checks
    // ---------------------------------------------------------------
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    a_wr_no_wait: assert property (dp_write |-> hreadyout)
        else $error("write data phase stalled");
    a_ctrl_write: assert property (dp_write && s_reg.ap_addr == `DIM_ADDR_CTRL |=>
        s_reg.unlock == $past(hwdata[`DIM_CTRL_UNLOCK]) && s_reg.ilk_en == $past(hwdata[`DIM_CTRL_ILK_EN]))
        else $error("control write not taken");
    a_ctrl_read: assert property (dp_rd_ctrl |=>
        hrdata[`DIM_CTRL_UNLOCK] == $past(s_reg.unlock) && hrdata[`DIM_CTRL_ILK_EN] == $past(s_reg.ilk_en))
        else $error("control read wrong");
    a_status_read: assert property (dp_rd_status |=> hrdata[4:0] == $past(chan_state) &&
        hrdata[`DIM_STAT_ILK_DIS] == $past(current_loop_disable) &&
        hrdata[`DIM_STAT_ANALOG] == $past(analog_level))
        else $error("status read wrong");
    a_unmapped_zero: assert property (rd_stall && !ap_in_chan && s_reg.ap_addr != `DIM_ADDR_CTRL &&
        s_reg.ap_addr != `DIM_ADDR_STATUS |=> hrdata == '0)
        else $error("unmapped read not zero");
    a_rd_hold: assert property (!rd_stall |=> $stable(hrdata))
        else $error("read data changed outside a read");
    a_bus_reset: assert property (@(posedge hclk) $rose(hresetn) |-> hrdata == '0 && hreadyout)
        else $error("bus outputs not idle after reset");
    a_ctrl_reset: assert property (@(posedge hclk) $rose(hresetn) |->
        s_reg.ilk_en && !s_reg.unlock)
        else $error("control flags not at reset defaults");
    a_fill_hold: assert property (s_reg.fill == `DIM_FILL_DONE |=> s_reg.fill == `DIM_FILL_DONE)
        else $error("fill counter left its end value");
    a_wr_en_start: assert property (!past_valid |-> !chan_wr_en)
        else $error("write enable set straight out of reset");
    a_wr_en_hold: assert property (chan_wr_en |=> chan_wr_en)
        else $error("write enable dropped");
    // masking is for a reassigned fifth input only
    a_ilk_masked: assert property (!s_reg.ilk_en |=> !current_loop_disable)
        else $error("interlock disable while masked");
    a_ilk_restore: assert property (chan_state[`DIM_INTERLOCK_CH] |=> !current_loop_disable)
        else $error("current loop held off with interlock closed");

    c_invert: cover property (s_reg.vtrue[0] == '0 && chan_out[0].level);
    c_cfg_write: cover property (s_reg.unlock && s_reg.ap_valid && s_reg.ap_write && ap_in_chan);
    c_ilk_trip: cover property ($rose(current_loop_disable));
    c_read: cover property (rd_stall ##1 hreadyout);
    c_clamp: cover property (s_reg.vtrue[2] == `DIM_VAL_MAX);

endmodule
`default_nettype wire

/* tb/dim_field_sw.sv */
// field contact model driving the five input terminals
`timescale 1ns/100ps
`default_nettype none
module dim_field_sw (
    input wire logic hclk,
    input wire logic [4:0] close_cmd,
    input wire logic [3:0] slow,
    output logic [4:0] term
);
    logic [4:0] pend;
    logic [3:0] cnt;
    initial begin
        term = 5'h00;
        pend = 5'h00;
        cnt = 4'h0;
    end
    // contacts settle slow+1 cycles after the edge that takes a command change
    always @(posedge hclk) begin
        if (close_cmd != pend) begin
            pend <= close_cmd;
            cnt <= slow;
        end else if (cnt != 4'h0) begin
            cnt <= cnt - 4'h1;
        end else begin
            term <= pend;
        end
    end
endmodule
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the digital input value mapper
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, analog_level, chan_wr_en, cld;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [4:0] cmd, term, chan_state;
    logic [3:0] slow;
    logic [15:0] analog_in;
    dim_pkg::dim_chan_s [4:0] chan_out;
    int err_count, cmp_count, cyc;
    dim_top i_dim_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .first_input_terminal(term[0]), .second_input_terminal(term[1]),
        .third_input_terminal(term[2]), .fourth_input_terminal(term[3]), .interlock_terminal(term[4]),
        .analog_in(analog_in), .analog_level(analog_level), .chan_state(chan_state),
        .chan_out(chan_out), .chan_wr_en(chan_wr_en), .current_loop_disable(cld));
    dim_field_sw i_dim_field_sw (.hclk(hclk), .close_cmd(cmd), .slow(slow), .term(term));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        bus(1'b0, a, 32'h0);
        chk(nm, q, e);
    endtask
    task settle(input logic [4:0] c);
        cmd <= c;
        repeat (12) @(posedge hclk);
        #1;
    endtask
    task outchk(input int i, input logic [15:0] v, input logic l);
        chk("out value", {16'h0, chan_out[i].value}, {16'h0, v});
        chk("out level", {31'h0, chan_out[i].level}, {31'h0, l});
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task t_reset;
        chk("resp", {31'h0, hresp}, 32'h0);
        rchk(8'h00, 32'h2, "ctrl");
        for (int i = 0; i < 5; i++) begin
            rchk(8'(8'h10 * (i + 1)), 32'h1, "vtrue");
            rchk(8'(8'h10 * (i + 1) + 8'h4), 32'h0, "vfalse");
        end
        rchk(8'h18, 32'h5A, "dest0");
        rchk(8'h28, 32'h76, "dest1");
        rchk(8'h38, 32'h77, "dest2");
        rchk(8'hF0, 32'h0, "unmapped");
        $display("reset test done");
    endtask
    task t_follow;
        settle(5'h1F);
        chk("state", {27'h0, chan_state}, 32'h1F);
        chk("wr_en", {31'h0, chan_wr_en}, 32'h1);
        for (int i = 0; i < 5; i++) outchk(i, 16'h1, 1'b1);
        slow <= 4'h5;
        settle(5'h0A);
        for (int i = 0; i < 5; i++) outchk(i, {15'h0, cmd[i]}, cmd[i]);
        slow <= 4'h0;
        rchk(8'h2C, 32'h1, "out reg");
        bus(1'b1, 8'h04, 32'h0);
        rchk(8'h04, 32'h2A, "status");
        $display("follow test done");
    endtask
    task t_lock;
        bus(1'b1, 8'h10, 32'h1234);
        rchk(8'h10, 32'h1, "locked");
        bus(1'b1, 8'h00, 32'h3);
        bus(1'b1, 8'h10, 32'h0);
        bus(1'b1, 8'h14, 32'h1);
        bus(1'b1, 8'h28, 32'hE);
        bus(1'b1, 8'h20, 32'h3E8);
        bus(1'b1, 8'h24, 32'hBB8);
        bus(1'b1, 8'h00, 32'h2);
        settle(5'h03);
        outchk(0, 16'h0, 1'b0);
        outchk(1, 16'h3E8, 1'b1);
        chk("dest", {21'h0, chan_out[1].dest}, 32'hE);
        settle(5'h00);
        outchk(0, 16'h1, 1'b1);
        outchk(1, 16'hBB8, 1'b1);
        $display("lock test done");
    endtask
    task t_clamp;
        bus(1'b1, 8'h00, 32'h3);
        bus(1'b1, 8'h30, 32'h7FFF);
        bus(1'b1, 8'h34, 32'h8000);
        bus(1'b1, 8'h00, 32'h2);
        rchk(8'h30, 32'h7530, "max");
        rchk(8'h34, 32'hFFFF8AD0, "min");
        settle(5'h00);
        outchk(2, 16'h8AD0, 1'b0);
        settle(5'h04);
        outchk(2, 16'h7530, 1'b1);
        $display("clamp test done");
    endtask
    task t_ilk;
        settle(5'h10);
        chk("ilk on", {31'h0, cld}, 32'h0);
        cmd <= 5'h00;
        repeat (5) @(posedge hclk);
        #1;
        chk("ilk off", {31'h0, cld}, 32'h1);
        bus(1'b1, 8'h00, 32'h0);
        repeat (3) @(posedge hclk);
        #1;
        chk("ilk masked", {31'h0, cld}, 32'h0);
        bus(1'b1, 8'h00, 32'h2);
        $display("interlock test done");
    endtask
    task ana(input logic [15:0] v, input logic e);
        analog_in <= v;
        repeat (3) @(posedge hclk);
        #1;
        chk("analog", {31'h0, analog_level}, {31'h0, e});
    endtask
    task t_analog;
        ana(16'h0001, 1'b1);
        ana(16'hFFFF, 1'b0);
        ana(16'h0000, 1'b0);
        $display("analog test done");
    endtask
    task results;
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // clock, timeout and main sequence
    // ----------------------------------------
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            results();
        end
    end
    initial begin
        {hsel, hwrite, haddr, hwdata, htrans, cmd, slow, analog_in, hresetn} = '0;
        hsize = 3'h2;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_follow();
        t_lock();
        t_clamp();
        t_ilk();
        t_analog();
        results();
    end
endmodule
`default_nettype wire
